// File: rtl/fesc_ctrl.sv
// Host controller driving a parallel NOR flash's embedded program and erase
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Host detects completion by polarity or toggle.
// - Host waits for completion before array access.
// - Further sector address within 50 microseconds.
// - Chip erase ends 55h@2AAh then 10h@555h.
// - Chip select may strobe writes, write low.
module fesc_ctrl
  import fesc_pkg::*;
#(
  parameter int READ_WAIT = RD_WAIT_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // AXI4-Lite slave
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  output logic [1:0]       s_axi_bresp_o,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  input  wire logic [7:0]  s_axi_araddr_i,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  // Flash pins
  output fesc_pins_t       pins_o,
  input  wire logic [15:0] flash_dq_i,
  input  wire logic        ready_busy_out_n_i,
  // Interrupt
  output logic             irq_o
);

  localparam int WAIT_W   = 4;
  localparam int READ_LAT = READ_WAIT + 1;

  // The wait counter must cover access plus sync, and must not wrap
  if (READ_WAIT < RD_WAIT_CYC || READ_WAIT > (1 << WAIT_W)) begin : g_read_wait_chk
    $error("READ_WAIT out of range for access plus sync");
  end

  // ***********************************************
  // Pin synchronisers
  // ***********************************************
  logic [DATA_W-1:0] dq_s1_r, dq_s2_r;
  logic              rb_s1_r, rb_s2_r, rb_s3_r;

  // Two stages before any logic sees the asynchronous pins
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
      // Ready is the idle level of the pin, so no false rising edge follows reset
      rb_s1_r <= 1'b1;
      rb_s2_r <= 1'b1;
      rb_s3_r <= 1'b1;
    end else begin
      dq_s1_r <= flash_dq_i;
      dq_s2_r <= dq_s1_r;
      rb_s1_r <= ready_busy_out_n_i;
      rb_s2_r <= rb_s1_r;
      rb_s3_r <= rb_s2_r;
    end
  end

  // ***********************************************
  // AXI4-Lite slave and registers
  // ***********************************************
  logic              wr_go, rd_go, start_p, done_p, busy;
  logic              bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0]       rdata_r, rdata_nxt, wmask;
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [31:0]       addr_r, addr_nxt, wdat_r, wdat_nxt;
  logic [IRQ_W-1:0]  irq_stat_r, irq_stat_nxt, irq_en_r, irq_en_nxt, irq_set, irq_clr;
  logic [DATA_W-1:0] rd_r;

  // Both address and data must be present; one write in flight at a time
  assign wr_go           = s_axi_awvalid_i && s_axi_wvalid_i && !bvalid_r;
  assign rd_go           = s_axi_arvalid_i && !rvalid_r;
  assign s_axi_awready_o = wr_go;
  assign s_axi_wready_o  = wr_go;
  assign s_axi_arready_o = rd_go;
  assign s_axi_bvalid_o  = bvalid_r;
  assign s_axi_bresp_o   = bresp_r;
  assign s_axi_rvalid_o  = rvalid_r;
  assign s_axi_rdata_o   = rdata_r;
  assign s_axi_rresp_o   = rresp_r;
  assign wmask = {{8{s_axi_wstrb_i[3]}}, {8{s_axi_wstrb_i[2]}},
                  {8{s_axi_wstrb_i[1]}}, {8{s_axi_wstrb_i[0]}}};
  // Start is refused while an algorithm runs, so no array access interrupts it
  assign start_p = wr_go && s_axi_awaddr_i == REG_CTRL && s_axi_wstrb_i[0]
                   && s_axi_wdata_i[CTRL_GO] && !busy;
  assign irq_set = {rb_s2_r && !rb_s3_r, done_p};
  assign irq_clr = (wr_go && s_axi_awaddr_i == REG_IRQ_CLR) ?
                   s_axi_wdata_i[IRQ_W-1:0] : '0;
  assign irq_o   = |(irq_stat_r & irq_en_r);

  // Register decode, response generation and sticky interrupt status
  always_comb begin
    bvalid_nxt   = bvalid_r && !s_axi_bready_i;
    bresp_nxt    = bresp_r;
    rvalid_nxt   = rvalid_r && !s_axi_rready_i;
    rresp_nxt    = rresp_r;
    rdata_nxt    = rdata_r;
    ctrl_nxt     = ctrl_r;
    addr_nxt     = addr_r;
    wdat_nxt     = wdat_r;
    irq_en_nxt   = irq_en_r;
    // Set wins over a clear in the same cycle
    irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
    if (wr_go) begin
      bvalid_nxt = 1'b1;
      bresp_nxt  = RESP_OKAY;
      case (s_axi_awaddr_i)
        REG_CTRL:    ctrl_nxt   = (ctrl_r & ~wmask[CTRL_W-1:0]) |
                                  (s_axi_wdata_i[CTRL_W-1:0] & wmask[CTRL_W-1:0]);
        REG_ADDR:    addr_nxt   = (addr_r & ~wmask) | (s_axi_wdata_i & wmask);
        REG_WDATA:   wdat_nxt   = (wdat_r & ~wmask) | (s_axi_wdata_i & wmask);
        REG_IRQ_EN:  irq_en_nxt = s_axi_wdata_i[IRQ_W-1:0];
        REG_IRQ_CLR: bresp_nxt  = RESP_OKAY;
        default:     bresp_nxt  = RESP_SLVERR;
      endcase
    end
    if (rd_go) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      rdata_nxt  = '0;
      case (s_axi_araddr_i)
        REG_CTRL:     rdata_nxt[CTRL_W-1:0] = ctrl_r;
        REG_ADDR:     rdata_nxt = addr_r;
        REG_WDATA:    rdata_nxt = wdat_r;
        REG_STATUS:   rdata_nxt[STAT_RB:STAT_BUSY] = {rb_s2_r, busy};
        REG_RDATA:    rdata_nxt[DATA_W-1:0] = rd_r;
        REG_IRQ_STAT: rdata_nxt[IRQ_W-1:0] = irq_stat_r;
        REG_IRQ_EN:   rdata_nxt[IRQ_W-1:0] = irq_en_r;
        default:      rresp_nxt = RESP_SLVERR;
      endcase
    end
  end

  // Bus and register state
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      bvalid_r   <= 1'b0;
      bresp_r    <= RESP_OKAY;
      rvalid_r   <= 1'b0;
      rresp_r    <= RESP_OKAY;
      rdata_r    <= '0;
      ctrl_r     <= CTRL_RST;
      addr_r     <= '0;
      wdat_r     <= '0;
      irq_stat_r <= '0;
      irq_en_r   <= '0;
    end else begin
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
      rvalid_r   <= rvalid_nxt;
      rresp_r    <= rresp_nxt;
      rdata_r    <= rdata_nxt;
      ctrl_r     <= ctrl_nxt;
      addr_r     <= addr_nxt;
      wdat_r     <= wdat_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_en_r   <= irq_en_nxt;
    end
  end

  // ***********************************************
  // Command sequencer
  // ***********************************************
  fesc_state_t       st_r, st_nxt;
  fesc_op_t          op_r, op_nxt;
  logic              tog_r, tog_nxt, cs_r, cs_nxt, have_prev_r, have_prev_nxt;
  logic [2:0]        step_r, step_nxt;
  logic [WAIT_W-1:0] wait_r, wait_nxt;
  logic [DATA_W-1:0] rd_nxt, prev_r, prev_nxt;
  logic [ADDR_W-1:0] op_addr_r, op_addr_nxt;
  logic [DATA_W-1:0] op_data_r, op_data_nxt;
  fesc_pins_t        pins_r, pins_nxt;
  fesc_cyc_t         cyc;
  logic [2:0]        last_step;
  logic              expect_pol;

  // Address/data of each command write
  function automatic fesc_cyc_t cmd_cycle(input fesc_op_t op, input logic [2:0] step,
                                          input logic [ADDR_W-1:0] a,
                                          input logic [DATA_W-1:0] d);
    fesc_cyc_t c;
    c = '{addr: ADR_UNLOCK1, data: CMD_UNLOCK1};
    case (step)
      3'h1, 3'h4: c = '{addr: ADR_UNLOCK2, data: CMD_UNLOCK2};
      3'h2:       c.data = (op == OP_PROG) ? CMD_PROG : CMD_ERASE;
      3'h3:       if (op == OP_PROG) c = '{addr: a, data: d};
      3'h5: begin
        // Sector picked by A12 and up; lower bits cleared
        if (op == OP_SECT) c = '{addr: {a[ADDR_W-1:SECT_LSB], {SECT_LSB{1'b0}}},
                                 data: CMD_SECT_GO};
        else c.data = CMD_CHIP_GO;
      end
      default: c = '{addr: ADR_UNLOCK1, data: CMD_UNLOCK1};
    endcase
    return c;
  endfunction

  assign busy      = (st_r != S_IDLE);
  assign pins_o    = pins_r;
  assign last_step = (op_r == OP_PROG) ? LAST_PROG_STEP : LAST_ERASE_STEP;
  // Program finishes showing true bit 7; erase finishes reading 1
  assign expect_pol = (op_r == OP_PROG) ? op_data_r[POL_BIT] : 1'b1;

  // Next state of the write/poll sequence
  always_comb begin
    st_nxt        = st_r;
    op_nxt        = op_r;
    tog_nxt       = tog_r;
    cs_nxt        = cs_r;
    step_nxt      = step_r;
    wait_nxt      = wait_r;
    rd_nxt        = rd_r;
    prev_nxt      = prev_r;
    have_prev_nxt = have_prev_r;
    op_addr_nxt   = op_addr_r;
    op_data_nxt   = op_data_r;
    pins_nxt      = pins_r;
    done_p        = 1'b0;
    case (st_r)
      S_IDLE: begin
        if (start_p) begin
          op_nxt        = fesc_op_t'(s_axi_wdata_i[CTRL_OP_LSB +: 2]);
          tog_nxt       = s_axi_wdata_i[CTRL_TOG];
          cs_nxt        = s_axi_wdata_i[CTRL_CS];
          op_addr_nxt   = addr_r[ADDR_W-1:0];
          op_data_nxt   = wdat_r[DATA_W-1:0];
          have_prev_nxt = 1'b0;
          wait_nxt      = '0;
          step_nxt      = '0;
          pins_nxt.addr = addr_r[ADDR_W-1:0];
          if (s_axi_wdata_i[CTRL_OP_LSB +: 2] == OP_READ) begin
            st_nxt        = S_RD;
            pins_nxt.ce_n = 1'b0;
            pins_nxt.oe_n = 1'b0;
          end else begin
            st_nxt = S_WR_LOW;
          end
        end
      end
      S_WR_LOW: begin
        st_nxt = S_WR_HIGH;
        if (cs_r) pins_nxt.ce_n = 1'b1;
        else pins_nxt.we_n = 1'b1;
      end
      S_WR_HIGH: begin
        if (step_r == last_step) begin
          // Command issued: poll the target address for status
          st_nxt        = S_RD;
          wait_nxt      = '0;
          pins_nxt      = '{addr: op_addr_r, dout: '0, dout_oe: 1'b0,
                            ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
        end else begin
          st_nxt   = S_WR_LOW;
          step_nxt = step_r + 3'h1;
        end
      end
      S_RD: begin
        wait_nxt = wait_r + WAIT_W'(1);
        if (wait_r == WAIT_W'(READ_WAIT - 1)) begin
          rd_nxt        = dq_s2_r;
          pins_nxt.ce_n = 1'b1;
          pins_nxt.oe_n = 1'b1;
          st_nxt        = S_CHECK;
        end
      end
      S_CHECK: begin
        prev_nxt      = rd_r;
        have_prev_nxt = 1'b1;
        wait_nxt      = '0;
        // Polarity bit or a stalled toggle bit ends the poll
        if (op_r == OP_READ || (!tog_r && rd_r[POL_BIT] == expect_pol) ||
            (tog_r && have_prev_r && rd_r[TOG_BIT] == prev_r[TOG_BIT])) begin
          st_nxt = S_IDLE;
          done_p = 1'b1;
        end else begin
          st_nxt        = S_RD;
          pins_nxt.ce_n = 1'b0;
          pins_nxt.oe_n = 1'b0;
        end
      end
      default: st_nxt = S_IDLE;
    endcase
    // Every command write drives its cycle with the strobes low
    cyc = cmd_cycle(op_nxt, step_nxt, op_addr_nxt, op_data_nxt);
    if (st_nxt == S_WR_LOW) begin
      pins_nxt = '{addr: cyc.addr, dout: cyc.data, dout_oe: 1'b1,
                   ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0};
    end
  end

  // Sequencer state
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r        <= S_IDLE;
      op_r        <= OP_READ;
      tog_r       <= 1'b0;
      cs_r        <= 1'b0;
      step_r      <= '0;
      wait_r      <= '0;
      rd_r        <= '0;
      prev_r      <= '0;
      have_prev_r <= 1'b0;
      op_addr_r   <= '0;
      op_data_r   <= '0;
      pins_r      <= '{addr: '0, dout: '0, dout_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    end else begin
      st_r        <= st_nxt;
      op_r        <= op_nxt;
      tog_r       <= tog_nxt;
      cs_r        <= cs_nxt;
      step_r      <= step_nxt;
      wait_r      <= wait_nxt;
      rd_r        <= rd_nxt;
      prev_r      <= prev_nxt;
      have_prev_r <= have_prev_nxt;
      op_addr_r   <= op_addr_nxt;
      op_data_r   <= op_data_nxt;
      pins_r      <= pins_nxt;
    end
  end

  // ***********************************************
  // Assertions
  // ***********************************************
  fesc_cyc_t last_wr_r;
  logic [9:0] gap_r;

  // Helper: previous command write and cycles since it
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      last_wr_r <= '0;
      gap_r     <= '0;
    end else if (st_r == S_WR_LOW) begin
      last_wr_r <= '{addr: pins_r.addr, data: pins_r.dout};
      gap_r     <= 10'h001;
    end else if (gap_r != 10'h3ff) begin
      gap_r     <= gap_r + 10'h001;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  chip_tail_a: assert property (
    (st_r == S_WR_LOW && op_r == OP_CHIP && step_r == LAST_ERASE_STEP) |->
    (pins_r.addr == ADR_UNLOCK1 && pins_r.dout == CMD_CHIP_GO &&
     last_wr_r.addr == ADR_UNLOCK2 && last_wr_r.data == CMD_UNLOCK2))
    else $error("chip erase not ended by 55h@2AAh then 10h@555h");

  sect_load_a: assert property (
    (st_r == S_WR_LOW && op_r == OP_SECT && step_r == LAST_ERASE_STEP) |->
    (gap_r < 10'(SECT_LOAD_CYC)))
    else $error("sector address written outside load window");

  cs_strobe_a: assert property (
    (st_r == S_WR_LOW && cs_r) |->
    (!pins_r.ce_n && !pins_r.we_n) ##1 (pins_r.ce_n && !pins_r.we_n))
    else $error("chip select strobe did not release with write held low");

  poll_addr_a: assert property (
    (busy && op_r != OP_READ && !pins_r.oe_n) |->
    (pins_r.addr == op_addr_r && pins_r.we_n && !pins_r.dout_oe))
    else $error("array accessed away from status address during algorithm");

  toggle_done_a: assert property (
    (st_r == S_CHECK && tog_r && have_prev_r && op_r != OP_READ &&
     rd_r[TOG_BIT] == prev_r[TOG_BIT]) |=> (st_r == S_IDLE && $rose(irq_stat_r[IRQ_DONE])
     || st_r == S_IDLE && $past(irq_stat_r[IRQ_DONE])))
    else $error("stalled toggle bit did not end the poll");

  pol_wait_a: assert property (
    (st_r == S_CHECK && !tog_r && op_r != OP_READ && rd_r[POL_BIT] != expect_pol) |=>
    (st_r == S_RD && !pins_r.oe_n) [*2])
    else $error("poll ended while polarity bit still inverted");

  read_lat_a: assert property (
    $rose(busy) && op_r == OP_READ |-> ##READ_LAT !busy)
    else $error("single read did not finish in fixed time");

  prog_done_c:  cover property (done_p && op_r == OP_PROG);
  chip_done_c:  cover property (done_p && op_r == OP_CHIP);
  cs_write_c:   cover property (st_r == S_WR_LOW && cs_r && op_r == OP_SECT);
  sect_done_c:  cover property (done_p && op_r == OP_SECT);

endmodule // fesc_ctrl

`default_nettype wire

// File: rtl/fesc_pkg.sv
// Constants, types and register map of the flash erase/program sequencer
package fesc_pkg;

  // ***********************************************
  // Widths of the parallel flash bus
  // ***********************************************
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;

  // ***********************************************
  // Register map (byte offsets on AXI4-Lite)
  // ***********************************************
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_ADDR     = 8'h04;
  localparam logic [7:0] REG_WDATA    = 8'h08;
  localparam logic [7:0] REG_STATUS   = 8'h0c;
  localparam logic [7:0] REG_RDATA    = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_EN   = 8'h18;
  localparam logic [7:0] REG_IRQ_CLR  = 8'h1c;

  // Control register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_TOG    = 2;
  localparam int CTRL_CS     = 3;
  localparam int CTRL_GO     = 4;
  localparam int CTRL_W      = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

  // Status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_RB   = 1;

  // Interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_RB   = 1;
  localparam int IRQ_W    = 2;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ***********************************************
  // Flash command set
  // ***********************************************
  localparam logic [ADDR_W-1:0] ADR_UNLOCK1 = 20'h00555;
  localparam logic [ADDR_W-1:0] ADR_UNLOCK2 = 20'h002aa;
  localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 16'h00aa;
  localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_PROG    = 16'h00a0;
  localparam logic [DATA_W-1:0] CMD_ERASE   = 16'h0080;
  localparam logic [DATA_W-1:0] CMD_CHIP_GO = 16'h0010;
  localparam logic [DATA_W-1:0] CMD_SECT_GO = 16'h0030;
  localparam int SECT_LSB        = 12;
  localparam int POL_BIT         = 7;
  localparam int TOG_BIT         = 6;
  localparam logic [2:0] LAST_PROG_STEP  = 3'h3;
  localparam logic [2:0] LAST_ERASE_STEP = 3'h5;

  // ***********************************************
  // Timing
  // ***********************************************
  localparam int CLK_NS        = 100;
  localparam int T_ACC_NS      = 70;
  localparam int SYNC_STAGES   = 2;
  localparam int RD_WAIT_CYC   = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
  localparam int SECT_LOAD_US  = 50;
  localparam int SECT_LOAD_CYC = (SECT_LOAD_US * 1000) / CLK_NS;

  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_PROG = 2'b01,
    OP_CHIP = 2'b10,
    OP_SECT = 2'b11
  } fesc_op_t;

  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_WR_LOW  = 3'b001,
    S_WR_HIGH = 3'b010,
    S_RD      = 3'b011,
    S_CHECK   = 3'b100
  } fesc_state_t;

  // Flash pins driven by the controller
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic              dout_oe;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
  } fesc_pins_t;

  // One bus write cycle of a command
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fesc_cyc_t;

endpackage

// File: sim/fesc_flash_model.sv
// Behavioural parallel NOR flash answering the controller's pins
`timescale 1ns/1ps
`default_nettype none
module fesc_flash_model
  import fesc_pkg::*;
#(
  parameter int PROG_NS = 3000,
  parameter int CHIP_NS = 9000,
  parameter int SECT_NS = 6000
) (
  // Controller pins
  input  wire fesc_pins_t    pins_i,
  // Flash outputs
  output logic [DATA_W-1:0] dq_o,
  output logic              ready_busy_out_n_o
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] pdata = 16'h0;
  logic [2:0]        step = 3'h0;
  logic              busy = 1'b0;
  logic              erasing = 1'b0;
  logic              tog = 1'b0;
  initial dq_o = 16'h5a5a;
  initial ready_busy_out_n_o = 1'b1;

  // Busy span; ready/busy falls well inside its limit
  task automatic launch(input int ns, input logic er);
    erasing = er;
    busy = 1'b1;
    fork
      begin
        #20 ready_busy_out_n_o = 1'b0;
        #(ns) busy = 1'b0;
        ready_busy_out_n_o = 1'b1;
      end
    join_none
  endtask

  // Command decoder; a wrong cycle drops back to the start, as a real part does
  task automatic decode(input fesc_cyc_t c);
    logic [ADDR_W-1:0] q[$];
    if (step == 3'h6) begin
      step = 3'h0;
      pdata = c.data;
      mem[c.addr] = (mem.exists(c.addr) ? mem[c.addr] : 16'hffff) & c.data;
      launch(PROG_NS, 1'b0);
    end else if (c.addr == ADR_UNLOCK1 && c.data == CMD_UNLOCK1 && step inside {0, 3})
      step = step + 3'h1;
    else if (c.addr == ADR_UNLOCK2 && c.data == CMD_UNLOCK2 && step inside {1, 4})
      step = step + 3'h1;
    else if (step == 3'h2 && c.addr == ADR_UNLOCK1 && c.data == CMD_PROG)
      step = 3'h6;
    else if (step == 3'h2 && c.addr == ADR_UNLOCK1 && c.data == CMD_ERASE)
      step = 3'h3;
    else if (step == 3'h5 && c.addr == ADR_UNLOCK1 && c.data == CMD_CHIP_GO) begin
      step = 3'h0;
      mem.delete();
      launch(CHIP_NS, 1'b1);
    end else if (step == 3'h5 && c.data == CMD_SECT_GO) begin
      step = 3'h0;
      foreach (mem[k]) if (k[19:12] == c.addr[19:12]) q.push_back(k);
      foreach (q[i]) mem.delete(q[i]);
      launch(SECT_NS, 1'b1);
    end else
      step = 3'h0;
  endtask

  // Latch when the earlier of the two strobes rises; writes while busy are lost
  always @(posedge pins_i.we_n or posedge pins_i.ce_n) begin
    if (pins_i.oe_n && (pins_i.we_n != pins_i.ce_n) && !busy)
      decode('{pins_i.addr, pins_i.dout});
  end

  // Status while busy, array when idle
  always @(negedge pins_i.oe_n or negedge pins_i.ce_n) begin
    if (!pins_i.oe_n && !pins_i.ce_n) begin
      if (busy) begin
        tog = ~tog;
        dq_o <= #30 {8'h00, erasing ? 1'b0 : ~pdata[POL_BIT], tog, 6'h00};
      end else
        dq_o <= #30 (mem.exists(pins_i.addr) ? mem[pins_i.addr] : 16'hffff);
    end
  end

  // Released bus shows a changing pattern, never the last value
  always @(posedge pins_i.oe_n or posedge pins_i.ce_n)
    dq_o <= #10 ~dq_o;
endmodule // fesc_flash_model
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench of the flash sequencer with a flash model
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fesc_pkg::*;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, rb_n;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [3:0]  wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp;
  logic [15:0] dq;
  fesc_pins_t  pins;
  int          err_total = 0;
  int          tests_run = 0;
  int          seed = 32'h387d;
  logic        saw_rb = 1'b0;

  always #50 clk_i = ~clk_i;

  fesc_ctrl dut (.clk_i(clk_i), .reset_i(reset_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .pins_o(pins), .flash_dq_i(dq),
    .ready_busy_out_n_i(rb_n), .irq_o(irq));
  fesc_flash_model flash (.pins_i(pins), .dq_o(dq), .ready_busy_out_n_o(rb_n));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Polarity bit expected while busy: complement of the data, 0 for an erase
  function automatic logic exp_pol(input logic erase, input logic [15:0] v);
    return erase ? 1'b0 : ~v[POL_BIT];
  endfunction

  // Address and data offered together, each released when its own ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY, input logic [3:0] st = 4'hf);
    logic aw_left, w_left;
    aw_left = 1'b1;
    w_left  = 1'b1;
    @(posedge clk_i);
    awvalid <= 1'b1; wvalid <= 1'b1; awaddr <= a; wdata <= d; wstrb <= st; bready <= 1'b1;
    while (aw_left || w_left) begin
      @(posedge clk_i);
      if (aw_left && awready) begin
        aw_left = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_left && wready) begin
        w_left = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge clk_i);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge clk_i);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do @(posedge clk_i); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk_i);
    rready <= 1'b0;
    d = rdata;
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  // Polls forever; only the watchdog ends a hang
  task automatic wait_idle();
    logic [31:0] s;
    do begin
      rd(REG_STATUS, s);
      if (!s[STAT_RB]) saw_rb = 1'b1;
    end while (s[STAT_BUSY]);
  endtask

  task automatic read_at(input logic [19:0] a, input logic [15:0] exp);
    logic [31:0] d;
    wr(REG_ADDR, {12'h0, a});
    wr(REG_CTRL, 32'h10);
    wait_idle();
    rd(REG_RDATA, d);
    chk({16'h0, d[15:0]}, {16'h0, exp});
  endtask

  task automatic end_of_test();
    if (err_total == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Watchdog at 50000 cycles, far beyond the expected run of under a thousand cycles
  initial begin
    #5_000_000;
    err_total++;
    end_of_test();
  end

  // ************************
  // Main sequence
  // ************************
  initial begin
    logic [31:0] d;
    logic [19:0] ad [4];
    logic [15:0] vd [4];
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(REG_CTRL, d);
    chk(d, 32'h0);
    rd(8'h20, d, RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'h24, 32'hffffffff, RESP_SLVERR);
    // Byte enables: only the low byte of the second write lands
    wr(REG_ADDR, 32'hffffffff);
    wr(REG_ADDR, 32'h0, RESP_OKAY, 4'h1);
    rd(REG_ADDR, d);
    chk(d, 32'hffffff00);
    // Idle ready pin must not look like a rising edge after reset
    rd(REG_IRQ_STAT, d);
    chk(d, 32'h0);
    wr(REG_IRQ_EN, 32'h1);
    // Program in all four completion and strobe styles, one sector each
    for (int m = 0; m < 4; m++) begin
      ad[m] = {m[3:0], 16'h0} | 20'($random(seed) & 32'h0fff);
      vd[m] = 16'($random(seed));
      wr(REG_ADDR, {12'h0, ad[m]});
      wr(REG_WDATA, {16'h0, vd[m]});
      wr(REG_CTRL, {28'h1, m[1], m[0], 2'b01});
      if (!m[0]) begin
        repeat (18) @(posedge clk_i);
        rd(REG_RDATA, d);
        chk({31'h0, d[7]}, {31'h0, exp_pol(1'b0, vd[m])});
      end
      wait_idle();
      chk({31'h0, irq}, 32'h1);
      wr(REG_IRQ_CLR, 32'h3);
      chk({31'h0, irq}, 32'h0);
      read_at(ad[m], vd[m]);
    end
    // Masked sector erase with chip select strobes: events recorded, no interrupt
    wr(REG_IRQ_EN, 32'h0);
    wr(REG_ADDR, {12'h0, ad[1]});
    wr(REG_CTRL, 32'h1b);
    repeat (30) @(posedge clk_i);
    rd(REG_RDATA, d);
    chk({31'h0, d[7]}, {31'h0, exp_pol(1'b1, 16'h0)});
    wait_idle();
    rd(REG_IRQ_STAT, d);
    chk({31'h0, d[IRQ_DONE]}, 32'h1);
    chk({31'h0, d[IRQ_RB]}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    read_at(ad[1], 16'hffff);
    read_at(ad[2], vd[2]);
    // Chip erase in toggle mode with the chip select strobing
    wr(REG_CTRL, 32'h1e);
    wait_idle();
    read_at(ad[2], 16'hffff);
    read_at(ad[3], 16'hffff);
    chk({31'h0, saw_rb}, 32'h1);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
